// ==== core/pcfc_top.sv ====
/*
  Command control register of the function, with the gating it applies
  to downstream requests, upstream requests, error messages, message
  interrupts and legacy interrupts; also the two status flags it governs.
  Assumes configuration requests and link events are synchronous
  single-cycle strobes from the link core on i_sys_clk.
*/
// What this block does
// - Command register at 04h, all bits zero after reset.
// - Bits 15 to 11 reserved, read as zero.
// - Bit 10 read/write, controls legacy interrupt signalling.
// - Bit 9 read-only zero; no fast back-to-back transactions.
// - Bit 8 read/write; error messages sent only while set.
// - Bit 7 hardwired zero; no address or data stepping.
// - Bit 6 read/write; gates setting of the poisoned data flag.
// - Poisoned data handling itself ignores bit 6.
// - Bit 5 read-only zero; no palette snooping.
// - Bit 4 read-only zero; no write-and-invalidate.
// - Bit 3 read-only zero; no special cycles.
// - Bit 2 read/write; no upstream requests while clear.
// - Bit 1 read/write; memory requests get unsupported-request while clear.
// - Bit 0 read-only zero; I/O requests get unsupported-request.
// - Poisoned data flag is status bit 8 at 06h.
// - Status bit 14 set when an error message is sent while enabled.
`timescale 1ns/1ps
module pcfc_top
  import pcfc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [11:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic i_rx_req_valid,
  input wire logic i_rx_req_io,
  input wire logic i_up_req,
  input wire logic i_err_evt,
  input wire logic i_poison_rx,
  input wire logic i_intx_req,
  input wire logic i_msi_req,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rd_valid,
  output logic [15:0] o_cmd,
  output logic o_rx_accept,
  output logic o_rx_ur,
  output logic o_up_grant,
  output logic o_up_refused,
  output logic o_err_msg_send,
  output logic o_poison_fwd,
  output logic o_intx_assert,
  output logic o_msi_send,
  output logic o_stat_par,
  output logic o_stat_err
);

  pcfc_state_t st_q;
  pcfc_state_t st_d;
  logic cfg_hit;
  logic [15:0] wr_mask;
  logic [15:0] stat_word;
  logic rx_en;
  logic err_set;
  logic par_set;
  logic err_clr;
  logic par_clr;

  // Command and status share one dword
  assign cfg_hit = (i_cfg_addr[11:2] == PCFC_CMD_OFF[11:2]);
  assign wr_mask = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

  always_comb begin
    stat_word = PCFC_STAT_FIXED;
    stat_word[PCFC_STAT_ERR] = st_q.err_flag;
    stat_word[PCFC_STAT_PAR] = st_q.par_flag;
  end

  // Only I/O enable (constant zero) or memory enable lets a request in
  assign rx_en = i_rx_req_io ? st_q.cmd[PCFC_CMD_IO_EN]
                             : st_q.cmd[PCFC_CMD_MEM_EN];
  assign err_set = i_err_evt & st_q.cmd[PCFC_CMD_ERR_EN];
  assign par_set = i_poison_rx & st_q.cmd[PCFC_CMD_PAR_EN];
  assign err_clr = i_cfg_wr & cfg_hit & i_cfg_be[3] & i_cfg_wdata[30];
  assign par_clr = i_cfg_wr & cfg_hit & i_cfg_be[3] & i_cfg_wdata[24];

  always_comb begin
    st_d = st_q;
    if (i_cfg_wr && cfg_hit) begin
      // Only writable bits of enabled bytes take data; the rest keep their value
      st_d.cmd = (st_q.cmd & ~(wr_mask & PCFC_CMD_RW_MASK)) |
        (i_cfg_wdata[15:0] & wr_mask & PCFC_CMD_RW_MASK);
    end
    // Set wins over a clear in the same cycle
    st_d.err_flag = err_set | (st_q.err_flag & ~err_clr);
    st_d.par_flag = par_set | (st_q.par_flag & ~par_clr);
    st_d.rd_valid = i_cfg_rd;
    if (i_cfg_rd && cfg_hit) begin
      st_d.rdata = {stat_word, st_q.cmd};
    end else begin
      st_d.rdata = 32'h0000_0000;
    end
    st_d.poison_fwd = i_poison_rx;
    st_d.intx = i_intx_req & ~st_q.cmd[PCFC_CMD_INTX_DIS];
    st_d.msi = i_msi_req & st_q.cmd[PCFC_CMD_BM_EN];
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= '0;
      st_q.cmd <= PCFC_CMD_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  pcfc_gate u_rx_gate (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_evt(i_rx_req_valid),
    .i_en(rx_en),
    .o_pass(o_rx_accept),
    .o_block(o_rx_ur)
  );

  pcfc_gate u_up_gate (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_evt(i_up_req),
    .i_en(st_q.cmd[PCFC_CMD_BM_EN]),
    .o_pass(o_up_grant),
    .o_block(o_up_refused)
  );

  pcfc_gate u_err_gate (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_evt(i_err_evt),
    .i_en(st_q.cmd[PCFC_CMD_ERR_EN]),
    .o_pass(o_err_msg_send),
    .o_block()
  );

  assign o_cfg_rdata = st_q.rdata;
  assign o_cfg_rd_valid = st_q.rd_valid;
  assign o_cmd = st_q.cmd;
  assign o_poison_fwd = st_q.poison_fwd;
  assign o_intx_assert = st_q.intx;
  assign o_msi_send = st_q.msi;
  assign o_stat_par = st_q.par_flag;
  assign o_stat_err = st_q.err_flag;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_rd_data;
    i_cfg_rd && cfg_hit |=> o_cfg_rd_valid &&
      o_cfg_rdata[15:0] == $past(o_cmd);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("command read data wrong");

  property p_resv;
    o_cmd[15:11] == 5'h00;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved command bits not zero");

  property p_intx_wr;
    i_cfg_wr && cfg_hit && i_cfg_be[1] |=>
      o_cmd[PCFC_CMD_INTX_DIS] == $past(i_cfg_wdata[10]);
  endproperty
  a_intx_wr: assert property (p_intx_wr)
    else $error("interrupt disable bit not written");

  property p_fbb;
    o_cmd[9] == 1'b0;
  endproperty
  a_fbb: assert property (p_fbb)
    else $error("fast back-to-back bit not zero");

  property p_err_gate;
    i_err_evt ##1 o_err_msg_send |-> $past(o_cmd[PCFC_CMD_ERR_EN]);
  endproperty
  a_err_gate: assert property (p_err_gate)
    else $error("error message sent while disabled");

  property p_step;
    o_cmd[7] == 1'b0 && o_cmd[5] == 1'b0;
  endproperty
  a_step: assert property (p_step)
    else $error("stepping or palette bit not zero");

  property p_par_set;
    $rose(o_stat_par) |-> $past(i_poison_rx && o_cmd[PCFC_CMD_PAR_EN]);
  endproperty
  a_par_set: assert property (p_par_set)
    else $error("poisoned data flag set without cause");

  property p_poison_fwd;
    i_poison_rx |=> o_poison_fwd;
  endproperty
  a_poison_fwd: assert property (p_poison_fwd)
    else $error("poisoned data not handled");

  property p_wi_sc;
    o_cmd[4] == 1'b0 && o_cmd[3] == 1'b0;
  endproperty
  a_wi_sc: assert property (p_wi_sc)
    else $error("write-invalidate or special cycle bit set");

  property p_up_gate;
    i_up_req && !o_cmd[PCFC_CMD_BM_EN] |=> o_up_refused && !o_up_grant;
  endproperty
  a_up_gate: assert property (p_up_gate)
    else $error("upstream request issued while disabled");

  property p_mem_ur;
    i_rx_req_valid && !i_rx_req_io && !o_cmd[PCFC_CMD_MEM_EN] |=>
      o_rx_ur && !o_rx_accept;
  endproperty
  a_mem_ur: assert property (p_mem_ur)
    else $error("memory request not refused");

  property p_io_ur;
    i_rx_req_valid && i_rx_req_io |=> o_rx_ur && !o_rx_accept;
  endproperty
  a_io_ur: assert property (p_io_ur)
    else $error("I/O request not refused");

  property p_err_flag;
    o_err_msg_send |-> o_stat_err;
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("error flag not set with message");

  property p_intx_off;
    o_cmd[PCFC_CMD_INTX_DIS] |=> !o_intx_assert;
  endproperty
  a_intx_off: assert property (p_intx_off)
    else $error("legacy interrupt while disabled");

  property p_ro_wr;
    (o_cmd & ~PCFC_CMD_RW_MASK) == 16'h0000;
  endproperty
  a_ro_wr: assert property (p_ro_wr)
    else $error("read-only command bit changed");

  property p_palette;
    o_cmd[5] == 1'b0;
  endproperty
  a_palette: assert property (p_palette)
    else $error("palette snoop bit not zero");

  property p_special;
    o_cmd[3] == 1'b0;
  endproperty
  a_special: assert property (p_special)
    else $error("special cycle bit not zero");

  property p_io_zero;
    o_cmd[PCFC_CMD_IO_EN] == 1'b0;
  endproperty
  a_io_zero: assert property (p_io_zero)
    else $error("I/O enable bit not zero");

  property p_mem_ok;
    i_rx_req_valid && !i_rx_req_io && o_cmd[PCFC_CMD_MEM_EN] |=>
      o_rx_accept && !o_rx_ur;
  endproperty
  a_mem_ok: assert property (p_mem_ok)
    else $error("enabled memory request not processed");

  property p_mem_wr;
    i_cfg_wr && cfg_hit && i_cfg_be[0] |=>
      o_cmd[PCFC_CMD_MEM_EN] == $past(i_cfg_wdata[1]);
  endproperty
  a_mem_wr: assert property (p_mem_wr)
    else $error("memory enable bit not written");

  property p_up_ok;
    i_up_req && o_cmd[PCFC_CMD_BM_EN] |=> o_up_grant && !o_up_refused;
  endproperty
  a_up_ok: assert property (p_up_ok)
    else $error("enabled upstream request not granted");

  property p_err_block;
    i_err_evt && !o_cmd[PCFC_CMD_ERR_EN] |=> !o_err_msg_send;
  endproperty
  a_err_block: assert property (p_err_block)
    else $error("error message sent while reporting disabled");

  property p_err_set;
    i_err_evt && o_cmd[PCFC_CMD_ERR_EN] |=> o_err_msg_send && o_stat_err;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error message or its flag missing");

  property p_par_on;
    i_poison_rx && o_cmd[PCFC_CMD_PAR_EN] |=> o_stat_par;
  endproperty
  a_par_on: assert property (p_par_on)
    else $error("poisoned data flag not set while enabled");

  property p_par_off;
    !o_stat_par && i_poison_rx && !o_cmd[PCFC_CMD_PAR_EN] |=> !o_stat_par;
  endproperty
  a_par_off: assert property (p_par_off)
    else $error("poisoned data flag set while disabled");

  property p_msi_free;
    i_msi_req && o_cmd[PCFC_CMD_BM_EN] |=> o_msi_send;
  endproperty
  a_msi_free: assert property (p_msi_free)
    else $error("message interrupt held back");

  property p_intx_on;
    i_intx_req && !o_cmd[PCFC_CMD_INTX_DIS] |=> o_intx_assert;
  endproperty
  a_intx_on: assert property (p_intx_on)
    else $error("legacy interrupt missing while allowed");

endmodule : pcfc_top

// ==== inc/pcfc_pkg.sv ====
/*
  Constants and state types for the function command control block.
  Assumes byte addresses in configuration space, dword-aligned accesses.
*/
package pcfc_pkg;

  // Register placement and reset values
  localparam logic [11:0] PCFC_CMD_OFF = 12'h004;
  localparam logic [11:0] PCFC_STAT_OFF = 12'h006;
  localparam logic [15:0] PCFC_CMD_RESET = 16'h0000;
  localparam logic [15:0] PCFC_CMD_RW_MASK = 16'h0546;
  localparam logic [15:0] PCFC_STAT_FIXED = 16'h0010;

  // Command field positions
  localparam int PCFC_CMD_INTX_DIS = 10;
  localparam int PCFC_CMD_ERR_EN = 8;
  localparam int PCFC_CMD_PAR_EN = 6;
  localparam int PCFC_CMD_BM_EN = 2;
  localparam int PCFC_CMD_MEM_EN = 1;
  localparam int PCFC_CMD_IO_EN = 0;

  // Status field positions, within the 16-bit status half
  localparam int PCFC_STAT_ERR = 14;
  localparam int PCFC_STAT_PAR = 8;

  typedef struct packed {
    logic pass;
    logic block;
  } pcfc_gate_t;

  typedef struct packed {
    logic [15:0] cmd;
    logic par_flag;
    logic err_flag;
    logic [31:0] rdata;
    logic rd_valid;
    logic poison_fwd;
    logic intx;
    logic msi;
  } pcfc_state_t;

endpackage : pcfc_pkg

// ==== core/pcfc_gate.sv ====
/*
  Registered event gate: an event passes or is blocked by an enable.
  Assumes the event and enable are synchronous to i_sys_clk.
*/
`timescale 1ns/1ps
module pcfc_gate
  import pcfc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_evt,
  input wire logic i_en,
  output logic o_pass,
  output logic o_block
);

  pcfc_gate_t st_q;
  pcfc_gate_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.pass = i_evt & i_en;
    st_d.block = i_evt & ~i_en;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pass = st_q.pass;
  assign o_block = st_q.block;

endmodule : pcfc_gate

// ==== bench/pcfc_rc_model.sv ====
/*
  Root complex model: issues configuration requests and link events.
  Assumes requests start just after a rising edge and last one cycle.
*/
`timescale 1ns/1ps
module pcfc_rc_model (
  input wire logic i_sys_clk,
  output logic o_cfg_wr,
  output logic o_cfg_rd,
  output logic [11:0] o_cfg_addr,
  output logic [3:0] o_cfg_be,
  output logic [31:0] o_cfg_wdata,
  output logic o_rx_req_valid,
  output logic o_rx_req_io,
  output logic o_up_req,
  output logic o_err_evt,
  output logic o_poison_rx,
  output logic o_msi_req
);
  initial begin
    {o_cfg_wr, o_cfg_rd, o_cfg_addr, o_cfg_be, o_cfg_wdata} = '0;
    {o_rx_req_valid, o_rx_req_io, o_up_req, o_err_evt} = '0;
    {o_poison_rx, o_msi_req} = '0;
  end

  // Kinds: 0 write, 1 read, 2 mem, 3 io, 4 up, 5 err, 6 poison, 7 msi
  task send(input logic [3:0] k, input logic [11:0] a,
            input logic [3:0] b, input logic [31:0] d);
    @(posedge i_sys_clk);
    #1;
    o_cfg_addr = a;
    o_cfg_be = b;
    o_cfg_wdata = d;
    case (k)
      0: o_cfg_wr = 1'b1;
      1: o_cfg_rd = 1'b1;
      2: o_rx_req_valid = 1'b1;
      3: {o_rx_req_valid, o_rx_req_io} = 2'h3;
      4: o_up_req = 1'b1;
      5: o_err_evt = 1'b1;
      6: o_poison_rx = 1'b1;
      default: o_msi_req = 1'b1;
    endcase
    @(posedge i_sys_clk);
    #1;
    {o_cfg_wr, o_cfg_rd, o_rx_req_valid, o_rx_req_io} = '0;
    {o_up_req, o_err_evt, o_poison_rx, o_msi_req} = '0;
    // Released address and data lines do not keep their last value; byte enables do
    o_cfg_addr = ~a;
    o_cfg_wdata = ~d;
  endtask : send
endmodule : pcfc_rc_model

// ==== bench/testbench.sv ====
/*
  Self-checking bench for the command control block.
  Assumes the root complex model drives every request input except i_intx_req, which the bench drives itself.
*/
`timescale 1ns/1ps
module testbench;
  import pcfc_pkg::*;
  logic i_sys_clk, i_resetn, i_intx_req;
  logic cw, cr, rv, rio, up, er, po, ms;
  logic [11:0] ad;
  logic [3:0] be;
  logic [31:0] wd, o_cfg_rdata, s;
  logic o_cfg_rd_valid, o_rx_accept, o_rx_ur, o_up_grant, o_up_refused;
  logic o_err_msg_send, o_poison_fwd, o_intx_assert, o_msi_send;
  logic o_stat_par, o_stat_err;
  logic [15:0] o_cmd, c;
  logic [39:0] q[$];
  logic [39:0] obs, exp_v;
  int err_total = 0;
  int checks_done = 0;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    err_total++; $display("FAIL %0t got %h exp %h", $time, a, b); end end

  pcfc_rc_model pcfc_rc_model_inst (.i_sys_clk(i_sys_clk), .o_cfg_wr(cw),
    .o_cfg_rd(cr), .o_cfg_addr(ad), .o_cfg_be(be), .o_cfg_wdata(wd),
    .o_rx_req_valid(rv), .o_rx_req_io(rio), .o_up_req(up),
    .o_err_evt(er), .o_poison_rx(po), .o_msi_req(ms));
  pcfc_top pcfc_top_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cfg_wr(cw), .i_cfg_rd(cr), .i_cfg_addr(ad), .i_cfg_be(be),
    .i_cfg_wdata(wd), .i_rx_req_valid(rv), .i_rx_req_io(rio),
    .i_up_req(up), .i_err_evt(er), .i_poison_rx(po),
    .i_intx_req(i_intx_req), .i_msi_req(ms), .o_cfg_rdata(o_cfg_rdata),
    .o_cfg_rd_valid(o_cfg_rd_valid), .o_cmd(o_cmd),
    .o_rx_accept(o_rx_accept), .o_rx_ur(o_rx_ur), .o_up_grant(o_up_grant),
    .o_up_refused(o_up_refused), .o_err_msg_send(o_err_msg_send),
    .o_poison_fwd(o_poison_fwd), .o_intx_assert(o_intx_assert),
    .o_msi_send(o_msi_send), .o_stat_par(o_stat_par),
    .o_stat_err(o_stat_err));

  function logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  function logic [39:0] rd(input logic [15:0] st, input logic [15:0] cm);
    return {8'h01, st, cm};
  endfunction : rd

  task op(input logic [3:0] k, input logic [11:0] a, input logic [3:0] b,
          input logic [31:0] d, input logic [39:0] e);
    if (e !== 40'h0) q.push_back(e);
    pcfc_rc_model_inst.send(k, a, b, d);
  endtask : op

  task conclude;
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Each result is matched against the oldest expectation
  always @(posedge i_sys_clk) begin
    #2;
    obs = {o_rx_accept, o_rx_ur, o_up_grant, o_up_refused, o_err_msg_send,
      o_poison_fwd, o_msi_send, o_cfg_rd_valid,
      o_cfg_rd_valid ? o_cfg_rdata : 32'h0};
    if (obs !== 40'h0) begin
      if (q.size() == 0) `CHK(obs, 40'h0)
      else begin
        exp_v = q.pop_front();
        `CHK(obs, exp_v)
      end
    end
  end

  initial begin
    #50000;
    err_total++;
    conclude();
  end

  initial begin
    i_resetn = 1'b0;
    i_intx_req = 1'b1;
    s = 32'h7DCC;
    repeat (6) @(posedge i_sys_clk);
    #1;
    i_resetn = 1'b1;
    op(1, 12'h004, 4'hF, 32'h0, rd(16'h0010, 16'h0000));
    for (int i = 0; i < 4; i++) begin
      s = xs(s);
      c = s[15:0] & 16'h0546;
      op(0, 12'h004, 4'h3, s, 40'h0);
      `CHK(o_cmd, c)
      op(1, 12'h004, 4'hF, ~s, rd(16'h0010, c));
    end
    for (int m = 0; m < 2; m++) begin
      c = m ? 16'h0546 : 16'h0000;
      op(0, 12'h004, 4'h3, {16'h0, m ? 16'hFFFF : 16'h0000}, 40'h0);
      `CHK(o_cmd, c)
      op(2, 12'h0, 4'h0, 32'h0, {m ? 7'h40 : 7'h20, 33'h0});
      `CHK(o_intx_assert, ~c[10])
      op(3, 12'h0, 4'h0, 32'h0, {7'h20, 33'h0});
      op(4, 12'h0, 4'h0, 32'h0, {m ? 7'h10 : 7'h08, 33'h0});
      op(5, 12'h0, 4'h0, 32'h0, {m ? 7'h04 : 7'h00, 33'h0});
      op(6, 12'h0, 4'h0, 32'h0, {7'h02, 33'h0});
      op(7, 12'h0, 4'h0, 32'h0, {m ? 7'h01 : 7'h00, 33'h0});
      `CHK(({o_stat_err, o_stat_par}), (m ? 2'h3 : 2'h0))
      op(1, 12'h004, 4'hF, 32'h0, rd(m ? 16'h4110 : 16'h0010, c));
      op(0, 12'h004, 4'h8, 32'h4100_0000, 40'h0);
      `CHK(({o_stat_err, o_stat_par}), 2'h0)
      op(1, 12'h004, 4'hF, 32'h0, rd(16'h0010, c));
    end
    op(1, 12'h008, 4'hF, 32'h0, 40'h01_0000_0000);
    repeat (3) @(posedge i_sys_clk);
    `CHK(q.size(), 0)
    conclude();
  end
endmodule : testbench
